// ===== hw/sdram_command_bank_logic.sv
`timescale 1ns/1ps
module sdram_command_bank_logic
  import sdram_pkg::*;
#(
  parameter int ROW_IDX_W          = 2,
  parameter int RP_CYCLES          = 4,
  parameter int REFRESH_CYCLE_TIME = 16,
  parameter int SELF_REF_PERIOD    = 195
)
(
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                reset,
  // Command and address pins
  input  wire logic                ck,
  input  wire logic                cke,
  input  wire logic                cs_n,
  input  wire logic                ras_n,
  input  wire logic                cas_n,
  input  wire logic                we_n,
  input  wire logic [BA_W-1:0]     ba,
  input  wire logic [ADDR_W-1:0]   addr,
  // Data pins
  input  wire logic [LANES-1:0]    byte_write_mask,
  input  wire logic [DQ_W-1:0]     dq_in,
  output logic      [DQ_W-1:0]     dq_out,
  output logic                     dq_oe_n,
  // Mode straps
  input  wire logic                otf_enable,
  input  wire logic                mode_chop,
  // Status
  output logic      [BANKS-1:0]    bank_open,
  output logic                     self_refresh_active,
  output logic                     refresh_busy,
  output logic      [ADDR_W-1:0]   refresh_row,
  output logic                     cal_busy,
  output logic                     cal_update
);
  import sdram_pkg::*;

  localparam int PIN_W   = 6 + BA_W + ADDR_W + LANES + DQ_W;
  localparam int MEM_A_W = BA_W + ROW_IDX_W + COL_W;

  typedef enum logic [1:0] {
    BURST_IDLE  = 2'h0,
    BURST_READ  = 2'h1,
    BURST_WRITE = 2'h2
  } burst_state_e;

  // ==========================================================
  // Pin synchroniser
  logic [PIN_W-1:0] pin_meta_reg;
  logic [PIN_W-1:0] pin_reg;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      pin_meta_reg <= '0;
      pin_reg      <= '0;
    end
    else
    begin
      pin_meta_reg <= {ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, byte_write_mask, dq_in};
      pin_reg      <= pin_meta_reg;
    end
  end

  logic                s_ck;
  logic                s_cke;
  logic                s_cs_n;
  logic                s_ras_n;
  logic                s_cas_n;
  logic                s_we_n;
  logic [BA_W-1:0]     s_ba;
  logic [ADDR_W-1:0]   s_addr;
  logic [LANES-1:0]    s_mask;
  logic [DQ_W-1:0]     s_dq;
  assign {s_ck, s_cke, s_cs_n, s_ras_n, s_cas_n, s_we_n, s_ba, s_addr, s_mask, s_dq} = pin_reg;

  // ==========================================================
  // Link clock edge and clock enable history
  logic ck_prev_reg;
  logic cke_prev_reg;
  logic ck_rise;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      ck_prev_reg <= 1'b0;
    else
      ck_prev_reg <= s_ck;
  end
  assign ck_rise = s_ck && !ck_prev_reg;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      cke_prev_reg <= 1'b0;
    else if (ck_rise)
      cke_prev_reg <= s_cke;
  end

  cmd_e cmd;
  logic take;
  assign cmd  = decode_cmd(s_cs_n, s_ras_n, s_cas_n, s_we_n, cke_prev_reg, s_cke);
  assign take = ck_rise && !self_refresh_active;

  // ==========================================================
  // Bank table
  bank_if banks ();
  bank_table #(.RP_CYCLES(RP_CYCLES)) u_bank_table (
    .clk_sys (clk_sys),
    .reset   (reset),
    .bus     (banks)
  );

  burst_state_e          burst_reg;
  logic [3:0]            beat_reg;
  logic [3:0]            len_reg;
  logic [COL_W-1:0]      col_reg;
  logic [BA_W-1:0]       bba_reg;
  logic                  ap_reg;
  logic                  last_beat;
  assign last_beat = (burst_reg != BURST_IDLE) && ck_rise && (beat_reg == len_reg - 4'h1);

  assign banks.tick     = ck_rise;
  assign banks.act      = take && cmd == CMD_ACTIVATE;
  assign banks.pre      = take && cmd == CMD_PRECHARGE;
  assign banks.pre_all  = s_addr[AUTO_PRECHARGE_BIT];
  assign banks.ba       = s_ba;
  assign banks.row      = s_addr;
  assign banks.auto_pre = last_beat && ap_reg;
  assign banks.auto_ba  = bba_reg;
  assign bank_open      = banks.open_vec;

  // ==========================================================
  // Burst engine
  logic start_rw;
  assign start_rw = take && burst_reg == BURST_IDLE && (cmd == CMD_READ || cmd == CMD_WRITE)
                  && banks.open_vec[s_ba];

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      burst_reg <= BURST_IDLE;
      beat_reg  <= '0;
      len_reg   <= EIGHT_BEAT_BURST;
      col_reg   <= '0;
      bba_reg   <= '0;
      ap_reg    <= 1'b0;
    end
    else if (start_rw)
    begin
      burst_reg <= (cmd == CMD_READ) ? BURST_READ : BURST_WRITE;
      beat_reg  <= '0;
      col_reg   <= s_addr[COL_W-1:0];
      bba_reg   <= s_ba;
      ap_reg    <= s_addr[AUTO_PRECHARGE_BIT];
      if (otf_enable)
        len_reg <= s_addr[BURST_CHOP_SELECT_BIT] ? EIGHT_BEAT_BURST : FOUR_BEAT_CHOP;
      else
        len_reg <= mode_chop ? FOUR_BEAT_CHOP : EIGHT_BEAT_BURST;
    end
    else if (last_beat)
      burst_reg <= BURST_IDLE;
    else if (burst_reg != BURST_IDLE && ck_rise)
      beat_reg <= beat_reg + 4'h1;
  end

  // ==========================================================
  // Storage array
  logic [DQ_W-1:0]    mem [2**MEM_A_W];
  logic [COL_W-1:0]   beat_col;
  logic [MEM_A_W-1:0] mem_idx;
  assign beat_col = (len_reg == FOUR_BEAT_CHOP)
                  ? {col_reg[COL_W-1], 2'(col_reg[1:0] + beat_reg[1:0])}
                  : COL_W'(col_reg + beat_reg[COL_W-1:0]);
  assign mem_idx  = {bba_reg, banks.open_row[bba_reg][ROW_IDX_W-1:0], beat_col};

  // One process owns the whole array
  always_ff @(posedge clk_sys)
  begin
    for (int ln = 0; ln < LANES; ln++)
    begin
      if (burst_reg == BURST_WRITE && ck_rise && !s_mask[ln])
        mem[mem_idx][ln*8 +: 8] <= s_dq[ln*8 +: 8];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      dq_out  <= '0;
      dq_oe_n <= 1'b1;
    end
    else if (burst_reg == BURST_READ && ck_rise)
    begin
      dq_out  <= mem[mem_idx];
      dq_oe_n <= 1'b0;
    end
    else if (ck_rise)
      dq_oe_n <= 1'b1;
  end

  // ==========================================================
  // Refresh and self refresh
  logic [7:0]  rfc_reg;
  logic [15:0] self_tmr_reg;
  logic        self_tick;
  assign self_tick    = self_refresh_active && self_tmr_reg == 16'(SELF_REF_PERIOD - 1);
  assign refresh_busy = (rfc_reg != '0);

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      refresh_row <= '0;
    else if ((take && cmd == CMD_REFRESH) || self_tick)
      refresh_row <= refresh_row + ADDR_W'(1);
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      rfc_reg <= '0;
    else if (take && cmd == CMD_REFRESH)
      rfc_reg <= 8'(REFRESH_CYCLE_TIME);
    else if (ck_rise && rfc_reg != '0)
      rfc_reg <= rfc_reg - 8'h01;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      self_refresh_active <= 1'b0;
    else if (take && cmd == CMD_SELF_REF && banks.open_vec == '0)
      self_refresh_active <= 1'b1;
    else if (self_refresh_active && s_cke)
      self_refresh_active <= 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset || !self_refresh_active || self_tick)
      self_tmr_reg <= '0;
    else
      self_tmr_reg <= self_tmr_reg + 16'h0001;
  end

  // ==========================================================
  // Impedance calibration
  logic [9:0] cal_cnt_reg;
  logic       init_done_reg;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      cal_cnt_reg   <= '0;
      init_done_reg <= 1'b0;
    end
    else if (take && cmd == CMD_ZQ && cal_cnt_reg == '0)
    begin
      if (!s_addr[AUTO_PRECHARGE_BIT])
        cal_cnt_reg <= 10'(SHORT_CAL_CYCLES);
      else if (!init_done_reg)
        cal_cnt_reg <= 10'(INIT_CALIBRATION_WINDOW);
      else
        cal_cnt_reg <= 10'(OPERATIONAL_CALIBRATION_WINDOW);
      if (s_addr[AUTO_PRECHARGE_BIT])
        init_done_reg <= 1'b1;
    end
    else if (ck_rise && cal_cnt_reg != '0)
      cal_cnt_reg <= cal_cnt_reg - 10'h001;
  end

  assign cal_busy = (cal_cnt_reg != '0);

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      cal_update <= 1'b0;
    else
      cal_update <= ck_rise && cal_cnt_reg == 10'h001;
  end
endmodule // sdram_command_bank_logic

// ===== hw/sdram_pkg.sv
package sdram_pkg;
  // ==========================================================
  // Geometry
  localparam int BANKS   = 8;
  localparam int BA_W    = 3;
  localparam int ADDR_W  = 16;
  localparam int DQ_W    = 16;
  localparam int LANES   = DQ_W / 8;
  localparam int COL_W   = 3;
  localparam int AUTO_PRECHARGE_BIT     = 10;
  localparam int BURST_CHOP_SELECT_BIT  = 12;

  // ==========================================================
  // Burst lengths, in beats
  localparam logic [3:0] FOUR_BEAT_CHOP   = 4'h4;
  localparam logic [3:0] EIGHT_BEAT_BURST = 4'h8;

  // ==========================================================
  // Calibration windows, in link clock cycles
  localparam int SHORT_CAL_CYCLES = 64;
  localparam int INIT_CALIBRATION_WINDOW        = 512;
  localparam int OPERATIONAL_CALIBRATION_WINDOW = 256;

  // ==========================================================
  // Commands
  typedef enum logic [3:0] {
    CMD_DESELECT  = 4'h0,
    CMD_NO_OP     = 4'h1,
    CMD_ACTIVATE  = 4'h2,
    CMD_READ      = 4'h3,
    CMD_WRITE     = 4'h4,
    CMD_PRECHARGE = 4'h5,
    CMD_REFRESH   = 4'h6,
    CMD_SELF_REF  = 4'h7,
    CMD_ZQ        = 4'h8,
    CMD_MODE_SET  = 4'h9
  } cmd_e;

  function automatic cmd_e decode_cmd(input logic cs_n, input logic ras_n, input logic cas_n,
                                      input logic we_n, input logic cke_prev, input logic cke_now);
    cmd_e c;
    c = CMD_NO_OP;
    if (cs_n || !cke_prev)
      c = CMD_DESELECT;
    else
      case ({ras_n, cas_n, we_n})
        3'h7: c = CMD_NO_OP;
        3'h3: c = CMD_ACTIVATE;
        3'h5: c = cke_now ? CMD_READ : CMD_NO_OP;
        3'h4: c = cke_now ? CMD_WRITE : CMD_NO_OP;
        3'h2: c = CMD_PRECHARGE;
        3'h1: c = cke_now ? CMD_REFRESH : CMD_SELF_REF;
        3'h6: c = CMD_ZQ;
        default: c = CMD_MODE_SET;
      endcase
    return c;
  endfunction
endpackage

// ===== hw/bank_if.sv
`timescale 1ns/1ps
interface bank_if;
  import sdram_pkg::*;
  logic                  act;
  logic                  pre;
  logic                  pre_all;
  logic [BA_W-1:0]       ba;
  logic [ADDR_W-1:0]     row;
  logic                  auto_pre;
  logic [BA_W-1:0]       auto_ba;
  logic                  tick;
  logic [BANKS-1:0]      open_vec;
  logic [BANKS-1:0]      precharging;
  logic [ADDR_W-1:0]     open_row [BANKS];
  modport table_side (input act, pre, pre_all, ba, row, auto_pre, auto_ba, tick,
                      output open_vec, precharging, open_row);
  modport ctrl_side (output act, pre, pre_all, ba, row, auto_pre, auto_ba, tick,
                     input open_vec, precharging, open_row);
endinterface

// ===== hw/bank_table.sv
`timescale 1ns/1ps
module bank_table
  import sdram_pkg::*;
#(
  parameter int RP_CYCLES = 4
)
(
  // Clock and reset
  input  wire logic  clk_sys,
  input  wire logic  reset,
  // Command side
  bank_if.table_side bus
);
  import sdram_pkg::*;

  // ==========================================================
  // Per-bank open row and precharge timer
  genvar b;
  generate
    for (b = 0; b < BANKS; b++)
    begin : g_bank
      logic [7:0] rp_reg;
      logic       hit;
      assign hit = (bus.pre && (bus.pre_all || bus.ba == BA_W'(b)))
                 || (bus.auto_pre && bus.auto_ba == BA_W'(b));
      always_ff @(posedge clk_sys)
      begin
        if (reset)
        begin
          bus.open_vec[b] <= 1'b0;
          bus.open_row[b] <= '0;
        end
        else if (hit)
          bus.open_vec[b] <= 1'b0;
        else if (bus.act && bus.ba == BA_W'(b))
        begin
          bus.open_vec[b] <= 1'b1;
          bus.open_row[b] <= bus.row;
        end
      end
      always_ff @(posedge clk_sys)
      begin
        if (reset)
          rp_reg <= '0;
        else if (hit && (bus.open_vec[b] || rp_reg != '0))
          rp_reg <= 8'(RP_CYCLES);
        else if (bus.tick && rp_reg != '0)
          rp_reg <= rp_reg - 8'h01;
      end
      assign bus.precharging[b] = (rp_reg != '0);
    end
  endgenerate
endmodule // bank_table

// ===== sim/sdram_command_bank_logic_properties.sv
`timescale 1ns/1ps
module sdram_command_bank_logic_checker
(
  // Clock and reset
  input wire logic                          clk_sys,
  input wire logic                          reset,
  // Command pins
  input wire logic                          cke,
  input wire logic                          cs_n,
  input wire logic                          ras_n,
  input wire logic                          cas_n,
  input wire logic                          we_n,
  // Status
  input wire logic                          dq_oe_n,
  input wire logic [sdram_pkg::BANKS-1:0]   bank_open,
  input wire logic                          self_refresh_active,
  input wire logic                          refresh_busy,
  input wire logic [sdram_pkg::ADDR_W-1:0]  refresh_row,
  input wire logic                          cal_busy,
  input wire logic                          cal_update
);
  import sdram_pkg::*;
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  a_cal_pulse_once: assert property (cal_update |=> !cal_update)
    else $error("cal update longer than one cycle");
  a_cal_update_end: assert property (cal_update |-> !cal_busy && ($past(cal_busy) || $past(cal_busy, 2)))
    else $error("cal update without calibration end");
  a_cal_busy_hold: assert property ($rose(cal_busy) |=> cal_busy [*8])
    else $error("calibration ended too soon");
  a_refresh_row_step: assert property (refresh_row != $past(refresh_row) |-> refresh_row == $past(refresh_row) + 16'h0001)
    else $error("refresh row jumped");
  a_refresh_busy_pair: assert property ($rose(refresh_busy) |-> refresh_row == $past(refresh_row) + 16'h0001)
    else $error("refresh without row advance");
  a_refresh_busy_hold: assert property ($rose(refresh_busy) |=> refresh_busy [*8])
    else $error("refresh ended too soon");
  a_self_ref_idle: assert property (self_refresh_active |-> bank_open == 8'h00 && dq_oe_n)
    else $error("activity in self refresh");
  a_self_ref_entry: assert property ($rose(self_refresh_active) |-> $past({cs_n, ras_n, cas_n, we_n, cke}, 2) == 5'h02)
    else $error("self refresh without command");
  a_bank_open_cmd: assert property ((bank_open & ~$past(bank_open)) != 8'h00 |-> $past({cs_n, ras_n, cas_n, we_n}, 2) == 4'h3)
    else $error("bank opened without activate");
  a_read_open_bank: assert property ($fell(dq_oe_n) |-> bank_open != 8'h00)
    else $error("read data from closed banks");
endmodule // sdram_command_bank_logic_checker

bind sdram_command_bank_logic sdram_command_bank_logic_checker sdram_command_bank_logic_checker_i (
  .clk_sys(clk_sys), .reset(reset), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
  .dq_oe_n(dq_oe_n), .bank_open(bank_open), .self_refresh_active(self_refresh_active),
  .refresh_busy(refresh_busy), .refresh_row(refresh_row), .cal_busy(cal_busy), .cal_update(cal_update)
);

// ===== sim/ctrl_model.sv
`timescale 1ns/1ps
module ctrl_model
(
  // Clock
  input  wire logic                        clk_sys,
  // Command pins
  output logic                             ck,
  output logic                             cke,
  output logic [3:0]                       pins,
  output logic [sdram_pkg::BA_W-1:0]       ba,
  output logic [sdram_pkg::ADDR_W-1:0]     addr,
  // Write data
  output logic [sdram_pkg::LANES-1:0]      mask,
  output logic [sdram_pkg::DQ_W-1:0]       wdata
);
  import sdram_pkg::*;
  initial
  begin
    ck = 1'h0;
    cke = 1'h0;
    pins = 4'hF;
    ba = 3'h0;
    addr = 16'h0000;
    mask = 2'h3;
    wdata = 16'h0000;
  end
  // ==========================================================
  // Link clock period, pins change at its fall
  task automatic cyc(input int pre);
    repeat (pre) @(posedge clk_sys);
    ck <= 1'h1;
    repeat (4) @(posedge clk_sys);
    ck <= 1'h0;
  endtask
  // Clock enable level, held low for the self refresh entry command and high for the others
  task automatic hold(input logic k);
    @(posedge clk_sys);
    cke <= k;
  endtask
  // One command, then no-op and released address
  task automatic send(input logic [3:0] p, input logic [2:0] b, input logic [15:0] a);
    @(posedge clk_sys);
    pins <= p;
    ba <= b;
    addr <= a;
    cyc(3);
    pins <= 4'h7;
    ba <= ~b;
    addr <= ~a;
  endtask
  // One write beat, then released data
  task automatic data(input logic [15:0] d, input logic [1:0] m);
    @(posedge clk_sys);
    wdata <= d;
    mask <= m;
    cyc(3);
    wdata <= ~d;
    mask <= ~m;
  endtask
endmodule // ctrl_model

// ===== sim/tb_sdram_command_bank_logic.sv
`timescale 1ns/1ps
module tb_sdram_command_bank_logic;
  import sdram_pkg::*;
  localparam int REF_CT = 16;
  localparam int SRP    = 195;
  logic        clk_sys;
  logic        reset;
  logic        otf;
  logic        chop;
  logic        ck;
  logic        cke;
  logic [3:0]  pins;
  logic [2:0]  ba;
  logic [15:0] addr;
  logic [1:0]  mask;
  logic [15:0] wdata;
  logic [15:0] dq_out;
  logic        dq_oe_n;
  logic [7:0]  bank_open;
  logic        self_refresh_active;
  logic        refresh_busy;
  logic [15:0] refresh_row;
  logic        cal_busy;
  logic        cal_update;
  logic [15:0] exp_mem [8];
  int          err_count = 0;
  int          comparisons = 0;
  int          upd_cnt = 0;
  // ==========================================================
  // Design and controller
  sdram_command_bank_logic #(.REFRESH_CYCLE_TIME(REF_CT), .SELF_REF_PERIOD(SRP)) sdram_command_bank_logic_i (
    .clk_sys(clk_sys), .reset(reset), .ck(ck), .cke(cke), .cs_n(pins[3]), .ras_n(pins[2]), .cas_n(pins[1]),
    .we_n(pins[0]), .ba(ba), .addr(addr), .byte_write_mask(mask), .dq_in(wdata), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n), .otf_enable(otf), .mode_chop(chop), .bank_open(bank_open),
    .self_refresh_active(self_refresh_active), .refresh_busy(refresh_busy), .refresh_row(refresh_row),
    .cal_busy(cal_busy), .cal_update(cal_update));
  ctrl_model ctrl_model_i (.clk_sys(clk_sys), .ck(ck), .cke(cke), .pins(pins), .ba(ba), .addr(addr),
    .mask(mask), .wdata(wdata));
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (cal_update === 1'h1)
      upd_cnt <= upd_cnt + 1;
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'h1)
    begin
      err_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic count_busy(input logic cal, output int n);
    n = 0;
    while ((cal ? cal_busy : refresh_busy) !== 1'h0 && n < 600)
    begin
      ctrl_model_i.cyc(4);
      @(negedge clk_sys);
      n++;
    end
    if (n >= 600)
    begin
      chk(1'h0, "wait bound");
      finish_test();
    end
  endtask
  task automatic cmd_check(input logic [3:0] p, input logic [2:0] b, input logic [15:0] a, input logic [7:0] e);
    ctrl_model_i.send(p, b, a);
    @(negedge clk_sys);
    chk(bank_open === e, "bank state");
  endtask
  task automatic burst(input logic w, input logic [2:0] st, input logic a12, input logic ap,
                       input logic [1:0] mk, input logic [7:0] tg);
    int n;
    logic [2:0] c;
    logic [15:0] d;
    logic [1:0] m;
    n = ((otf === 1'h1) ? a12 : !chop) ? 8 : 4;
    ctrl_model_i.send({3'h2, !w}, 3'h3, {3'h0, a12, 1'h0, ap, 7'h00, st});
    for (int i = 0; i < n; i++)
    begin
      c = (n == 8) ? st + 3'(i) : {st[2], st[1:0] + 2'(i)};
      m = mk & {i[0], !i[0]};
      d = {tg + 8'(c), ~tg + 8'(c)};
      if (w)
      begin
        ctrl_model_i.data(d, m);
        if (!m[0])
          exp_mem[c][7:0] = d[7:0];
        if (!m[1])
          exp_mem[c][15:8] = d[15:8];
      end
      else
      begin
        ctrl_model_i.cyc(4);
        @(negedge clk_sys);
        chk(dq_oe_n === 1'h0 && dq_out === exp_mem[c], "read beat");
      end
    end
    ctrl_model_i.cyc(4);
    @(negedge clk_sys);
    chk(dq_oe_n === 1'h1 && bank_open[3] === !ap, "burst end");
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_cal();
    int n;
    int u;
    int cal_len [3] = '{INIT_CALIBRATION_WINDOW, OPERATIONAL_CALIBRATION_WINDOW, SHORT_CAL_CYCLES};
    for (int k = 0; k < 3; k++)
    begin
      u = upd_cnt;
      ctrl_model_i.send(4'h6, 3'h0, (k < 2) ? 16'h0400 : 16'h0000);
      @(negedge clk_sys);
      chk(cal_busy === 1'h1, "cal start");
      count_busy(1'h1, n);
      repeat (3) @(negedge clk_sys);
      chk(n == cal_len[k] && upd_cnt == u + 1, "cal length");
    end
    $display("calibration done");
  endtask
  task automatic t_pre();
    cmd_check(4'h3, 3'h0, 16'h0001, 8'h01);
    cmd_check(4'h3, 3'h1, 16'h0002, 8'h03);
    cmd_check(4'h3, 3'h2, 16'h0003, 8'h07);
    cmd_check(4'hB, 3'h5, 16'h0000, 8'h07);
    cmd_check(4'h7, 3'h6, 16'h0000, 8'h07);
    cmd_check(4'h2, 3'h1, 16'h0000, 8'h05);
    cmd_check(4'h2, 3'h1, 16'h0000, 8'h05);
    cmd_check(4'h2, 3'h1, 16'h0400, 8'h00);
    $display("precharge done");
  endtask
  task automatic t_rw();
    cmd_check(4'h3, 3'h3, 16'h0001, 8'h08);
    burst(1'h1, 3'h0, 1'h1, 1'h0, 2'h0, 8'h10);
    burst(1'h1, 3'h6, 1'h0, 1'h0, 2'h3, 8'h20);
    burst(1'h0, 3'h5, 1'h1, 1'h0, 2'h0, 8'h00);
    @(posedge clk_sys);
    otf <= 1'h0;
    chop <= 1'h1;
    @(negedge clk_sys);
    burst(1'h0, 3'h2, 1'h1, 1'h1, 2'h0, 8'h00);
    cmd_check(4'h3, 3'h2, 16'h0001, 8'h04);
    cmd_check(4'h2, 3'h2, 16'h0000, 8'h00);
    $display("read write done");
  endtask
  task automatic t_ref();
    int n;
    logic [15:0] r;
    r = refresh_row;
    ctrl_model_i.send(4'h1, 3'h7, 16'hFFFF);
    @(negedge clk_sys);
    chk(refresh_row === r + 16'h0001 && refresh_busy === 1'h1, "refresh start");
    count_busy(1'h0, n);
    chk(n == REF_CT, "refresh length");
    $display("refresh done");
  endtask
  task automatic t_self();
    logic [15:0] r;
    ctrl_model_i.hold(1'h0);
    ctrl_model_i.send(4'h1, 3'h0, 16'h0000);
    @(negedge clk_sys);
    chk(self_refresh_active === 1'h1, "self refresh entry");
    r = refresh_row;
    repeat (2 * SRP + 4) @(negedge clk_sys);
    chk(refresh_row === r + 16'h0002, "self refresh rows");
    ctrl_model_i.hold(1'h1);
    repeat (5) @(negedge clk_sys);
    chk(self_refresh_active === 1'h0, "self refresh exit");
    ctrl_model_i.send(4'h7, 3'h0, 16'h0000);
    cmd_check(4'h3, 3'h3, 16'h0001, 8'h08);
    @(posedge clk_sys);
    chop <= 1'h0;
    @(negedge clk_sys);
    burst(1'h0, 3'h0, 1'h1, 1'h0, 2'h0, 8'h00);
    $display("self refresh done");
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    clk_sys = 1'h0;
    reset = 1'h1;
    otf = 1'h1;
    chop = 1'h0;
    repeat (10) @(posedge clk_sys);
    reset <= 1'h0;
    @(negedge clk_sys);
    chk(bank_open === 8'h00 && dq_oe_n === 1'h1 && refresh_row === 16'h0000 && cal_busy === 1'h0, "reset");
    ctrl_model_i.hold(1'h1);
    ctrl_model_i.send(4'h7, 3'h0, 16'h0000);
    t_cal();
    t_pre();
    t_rw();
    t_ref();
    t_self();
    finish_test();
  end
endmodule // tb_sdram_command_bank_logic
